// *** rtl/sos_pkg.sv ***
/*
 * Package for the status output selector: function codes, reset selector
 * values, the register map and timing constants.
 * Assumes a 25 MHz system clock and an APB register bus with 32-bit data.
 */
// Functional notes
// - Selector codes 0..36; third output defaults 20.
// - Relay selector defaults to 08, fault.
// - First output defaults to 01, operational.
// - Second output defaults to 02, frequency attained.
// - Code 01: output active or run on.
// - Code 02: output frequency reached command.
// - Code 03: command below minimum frequency.
// - Code 04: follows over-torque detector exactly.
// - Code 05: power stage inhibited, input forced.
// - Code 06: bus undervoltage detected.
// - Code 07: commands come from terminals.
// - Code 08: any protective fault active.
// - Codes 09/22: target frequency one/two reached.
// - Code 10 sequencer running; 13 paused.
// - Code 11: 0.5 s pulse per step.
// - Code 12: 0.5 s pulse per cycle.
// - Codes 14/15: final/preliminary count reached.
// - Code 19: heatsink above 85 C.
// - Code 20 ready; 21 emergency stop.
// - Code 24: on unless output frequency present.
// - Code 25: current below minimum.
// - Code 29: brake hysteresis release/engage.
package sos_pkg;

    // Number of status outputs: relay, then three open terminal outputs.
    localparam int NUM_OUT = 4;
    // Width of one selector code.
    localparam int CODE_W  = 6;

    // Function codes.
    localparam logic [5:0] FN_NONE       = 6'h00;
    localparam logic [5:0] FN_RUNNING    = 6'h01;
    localparam logic [5:0] FN_FREQ_MET   = 6'h02;
    localparam logic [5:0] FN_ZERO_CMD   = 6'h03;
    localparam logic [5:0] FN_TORQUE     = 6'h04;
    localparam logic [5:0] FN_INHIBIT    = 6'h05;
    localparam logic [5:0] FN_UNDERVOLT  = 6'h06;
    localparam logic [5:0] FN_TERM_CMD   = 6'h07;
    localparam logic [5:0] FN_FAULT      = 6'h08;
    localparam logic [5:0] FN_TARGET1    = 6'h09;
    localparam logic [5:0] FN_SEQ_RUN    = 6'h0a;
    localparam logic [5:0] FN_SEQ_STEP   = 6'h0b;
    localparam logic [5:0] FN_SEQ_DONE   = 6'h0c;
    localparam logic [5:0] FN_SEQ_PAUSE  = 6'h0d;
    localparam logic [5:0] FN_CNT_FINAL  = 6'h0e;
    localparam logic [5:0] FN_CNT_PRELIM = 6'h0f;
    localparam logic [5:0] FN_HEATSINK   = 6'h13;
    localparam logic [5:0] FN_READY      = 6'h14;
    localparam logic [5:0] FN_ESTOP      = 6'h15;
    localparam logic [5:0] FN_TARGET2    = 6'h16;
    localparam logic [5:0] FN_NO_FREQ    = 6'h18;
    localparam logic [5:0] FN_LOW_CURR   = 6'h19;
    localparam logic [5:0] FN_BRAKE      = 6'h1d;
    localparam logic [5:0] FN_MAX        = 6'h24;

    // Selector values after reset, per output.
    localparam logic [5:0] RST_SEL_RELAY = 6'h08;
    localparam logic [5:0] RST_SEL_ONE   = 6'h01;
    localparam logic [5:0] RST_SEL_TWO   = 6'h02;
    localparam logic [5:0] RST_SEL_THREE = 6'h14;

    // Register byte addresses.
    localparam logic [11:0] ADDR_SEL_RELAY = 12'h000;
    localparam logic [11:0] ADDR_SEL_ONE   = 12'h004;
    localparam logic [11:0] ADDR_SEL_TWO   = 12'h008;
    localparam logic [11:0] ADDR_SEL_THREE = 12'h00c;
    localparam logic [11:0] ADDR_STATUS    = 12'h010;
    localparam logic [11:0] ADDR_CONDITION = 12'h014;

    // Pulse length for sequencer events.
    localparam int CLK_HZ       = 25000000;
    localparam int PULSE_MS     = 500;
    localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
    localparam int PULSE_W      = 24;

endpackage

// *** rtl/sos_status_output_selector.sv ***
/*
 * Status output selector: four status outputs, each steered by a software
 * selector to one of the drive's internal condition functions.
 * Assumes all condition inputs are synchronous to sys_clk and that an APB
 * master reaches the selector registers.
 */
`timescale 1ns/1ps
`default_nettype none

module sos_status_output_selector #(
    parameter int PULSE_LEN = sos_pkg::PULSE_CYCLES
) (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Drive condition inputs.
    input  wire logic        output_active,
    input  wire logic        run_command,
    input  wire logic        freq_at_command,
    input  wire logic        command_below_min,
    input  wire logic        over_torque,
    input  wire logic        output_inhibit,
    input  wire logic        inhibit_forced_by_input,
    input  wire logic        bus_undervoltage,
    input  wire logic        command_from_terminals,
    input  wire logic        protective_fault,
    input  wire logic        target_one_reached,
    input  wire logic        target_two_reached,
    input  wire logic        sequencer_running,
    input  wire logic        sequencer_paused,
    input  wire logic        sequencer_step_reached,
    input  wire logic        sequencer_cycle_done,
    input  wire logic        count_final_reached,
    input  wire logic        count_prelim_reached,
    input  wire logic        heatsink_warning,
    input  wire logic        drive_powered,
    input  wire logic        abnormality,
    input  wire logic        emergency_stop,
    input  wire logic        output_freq_present,
    input  wire logic        current_below_min,
    input  wire logic        freq_at_brake_release,
    input  wire logic        freq_at_brake_engage,
    input  wire logic        stop_command,
    // Status outputs.
    output logic             relay_normally_open_contact,
    output logic             relay_normally_closed_contact,
    output logic             status_output_one,
    output logic             status_output_two,
    output logic             status_output_three
);
    import sos_pkg::*;

    // Pulse counter load value, cut to the counter width.
    localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(PULSE_LEN);

    // Selector registers, one per output.
    logic [CODE_W-1:0]  sel_code [NUM_OUT];
    // Registered status outputs.
    logic [NUM_OUT-1:0] out_q;
    // Combinational next value of each output.
    logic [NUM_OUT-1:0] next_out;
    // Remaining cycles of the step and cycle-done pulses.
    logic [PULSE_W-1:0] step_cnt;
    logic [PULSE_W-1:0] done_cnt;
    // Edge detection history for the sequencer events.
    logic               step_prev;
    logic               done_prev;
    // Mechanical brake hysteresis state.
    logic               brake_q;
    // Stop command latched until the brake engages or is released.
    logic               stop_seen;
    // Bus decode helpers.
    logic               bus_access;
    logic               addr_hit;
    logic [31:0]        next_rdata;

    // The slave always answers in the access cycle, so no wait states.
    assign pready     = 1'b1;
    assign bus_access = psel & penable;

    // Address decode: unmapped addresses answer with an error.
    always_comb begin
        case (paddr)
            ADDR_SEL_RELAY, ADDR_SEL_ONE, ADDR_SEL_TWO, ADDR_SEL_THREE,
            ADDR_STATUS, ADDR_CONDITION: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    assign pslverr = bus_access & ~addr_hit;

    // Read data mux; registered so the data output comes from a flip-flop.
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (paddr)
            ADDR_SEL_RELAY: next_rdata = {26'h0, sel_code[0]};
            ADDR_SEL_ONE:   next_rdata = {26'h0, sel_code[1]};
            ADDR_SEL_TWO:   next_rdata = {26'h0, sel_code[2]};
            ADDR_SEL_THREE: next_rdata = {26'h0, sel_code[3]};
            ADDR_STATUS:    next_rdata = {28'h0, out_q};
            ADDR_CONDITION: next_rdata = {29'h0, brake_q, (done_cnt != '0),
                                          (step_cnt != '0)};
            default:        next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the setup cycle and stands through access.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= next_rdata;
        end
    end

    // Selector registers; codes above the top code are refused.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_sel
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    sel_code[gi] <= (gi == 0) ? RST_SEL_RELAY :
                                    (gi == 1) ? RST_SEL_ONE :
                                    (gi == 2) ? RST_SEL_TWO :
                                    RST_SEL_THREE;
                end else if (bus_access && pwrite &&
                             paddr == ADDR_SEL_RELAY + 12'(4 * gi) &&
                             pwdata[CODE_W-1:0] <= FN_MAX) begin
                    sel_code[gi] <= pwdata[CODE_W-1:0];
                end
            end
        end
    endgenerate

    // Step pulse: 0.5 s stretch on each step-reached rising edge.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            step_prev <= 1'b0;
            step_cnt  <= '0;
        end else begin
            step_prev <= sequencer_step_reached;
            if (sequencer_step_reached & ~step_prev) begin
                step_cnt <= PULSE_LOAD;
            end else if (step_cnt != '0) begin
                step_cnt <= step_cnt - 1'b1;
            end
        end
    end

    // Cycle-done pulse: 0.5 s stretch on each completed program cycle.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            done_prev <= 1'b0;
            done_cnt  <= '0;
        end else begin
            done_prev <= sequencer_cycle_done;
            if (sequencer_cycle_done & ~done_prev) begin
                done_cnt <= PULSE_LOAD;
            end else if (done_cnt != '0) begin
                done_cnt <= done_cnt - 1'b1;
            end
        end
    end

    // Brake control: set at release threshold, clear at engage after stop.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            brake_q   <= 1'b0;
            stop_seen <= 1'b0;
        end else begin
            if (freq_at_brake_release) begin
                brake_q   <= 1'b1;
                stop_seen <= 1'b0;
            end else if ((stop_seen | stop_command) & freq_at_brake_engage) begin
                brake_q   <= 1'b0;
                stop_seen <= 1'b0;
            end else if (stop_command) begin
                stop_seen <= 1'b1;
            end
        end
    end

    // Function selection per output.
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
            always_comb begin
                case (sel_code[gi])
                    FN_RUNNING:    next_out[gi] = output_active | run_command;
                    FN_FREQ_MET:   next_out[gi] = freq_at_command;
                    FN_ZERO_CMD:   next_out[gi] = command_below_min;
                    FN_TORQUE:     next_out[gi] = over_torque;
                    FN_INHIBIT:    next_out[gi] = output_inhibit |
                                                  inhibit_forced_by_input;
                    FN_UNDERVOLT:  next_out[gi] = bus_undervoltage;
                    FN_TERM_CMD:   next_out[gi] = command_from_terminals;
                    FN_FAULT:      next_out[gi] = protective_fault;
                    FN_TARGET1:    next_out[gi] = target_one_reached;
                    FN_TARGET2:    next_out[gi] = target_two_reached;
                    FN_SEQ_RUN:    next_out[gi] = sequencer_running;
                    FN_SEQ_PAUSE:  next_out[gi] = sequencer_paused;
                    FN_SEQ_STEP:   next_out[gi] = (step_cnt != '0);
                    FN_SEQ_DONE:   next_out[gi] = (done_cnt != '0);
                    FN_CNT_FINAL:  next_out[gi] = count_final_reached;
                    FN_CNT_PRELIM: next_out[gi] = count_prelim_reached;
                    FN_HEATSINK:   next_out[gi] = heatsink_warning;
                    FN_READY:      next_out[gi] = drive_powered & ~abnormality;
                    FN_ESTOP:      next_out[gi] = emergency_stop;
                    FN_NO_FREQ:    next_out[gi] = ~output_freq_present;
                    FN_LOW_CURR:   next_out[gi] = current_below_min;
                    FN_BRAKE:      next_out[gi] = brake_q;
                    default:       next_out[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    // Output register; all four bits clear in reset, so only the relay's normally closed contact is on.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_q <= '0;
        end else begin
            out_q <= next_out;
        end
    end

    // Relay contacts are complementary views of one coil.
    assign relay_normally_open_contact   = out_q[0];
    assign relay_normally_closed_contact = ~out_q[0];
    assign status_output_one             = out_q[1];
    assign status_output_two             = out_q[2];
    assign status_output_three           = out_q[3];

endmodule // sos_status_output_selector

`default_nettype wire

// *** testbench/sos_load_model.sv ***
/* Model of the relay coil and terminal loads driven by the selector.
   Assumes the loads respond within one clock cycle. */
`timescale 1ns/1ps
`default_nettype none
module sos_load_model (
    // Clock.
    input  wire logic       sys_clk,
    // Relay contacts and terminal outputs.
    input  wire logic       contact_no,
    input  wire logic       contact_nc,
    input  wire logic [2:0] terminals,
    // Energised loads: outputs three, two, one, then the relay.
    output logic      [3:0] load_seen
);
    // A relay whose two contacts agree is stuck, so it reads as released.
    always_ff @(posedge sys_clk) begin
        load_seen <= {terminals, contact_no & ~contact_nc};
    end
endmodule // sos_load_model
`default_nettype wire

// *** testbench/sos_sel_asserts.sv ***
/* Checker for the status output selector, watching output one only.
   Assumes its selector is written only through zero-wait APB writes. */
`timescale 1ns/1ps
`default_nettype none
module sos_sel_asserts
    import sos_pkg::*;
(
    // Clock, reset and bus.
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    // Conditions.
    input wire logic        output_active,
    input wire logic        run_command,
    input wire logic        over_torque,
    input wire logic        output_inhibit,
    input wire logic        inhibit_forced_by_input,
    input wire logic        protective_fault,
    input wire logic        drive_powered,
    input wire logic        abnormality,
    input wire logic        output_freq_present,
    input wire logic        sequencer_step_reached,
    // Output.
    input wire logic        status_output_one
);
    logic [5:0] sel1;  // Shadow of the selector of output one.
    logic [5:0] prev1; // Shadow one cycle late.
    logic [1:0] up;    // Edges since reset, saturating.
    // Tracks selector writes; codes above the top code are dropped.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel1  <= RST_SEL_ONE;
            prev1 <= RST_SEL_ONE;
            up    <= 2'h0;
        end else begin
            prev1 <= sel1;
            if (up != 2'h3) up <= up + 2'h1;
            if (psel && penable && pwrite && pready && paddr == ADDR_SEL_ONE
                && pwdata[5:0] <= FN_MAX) sel1 <= pwdata[5:0];
        end
    end
    // Settled selector, far enough from reset to judge the output.
    wire logic st = (up == 2'h3) && (sel1 == prev1);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence step_rise;
        st && sel1 == FN_SEQ_STEP && $rose(sequencer_step_reached);
    endsequence
    sequence held8;
        status_output_one [*8];
    endsequence
    chk_run_follow: assert property (st && sel1 == FN_RUNNING |->
        status_output_one == $past(output_active || run_command))
        else $error("Output one does not follow the running state.");
    chk_torque_exact: assert property (st && sel1 == FN_TORQUE |->
        status_output_one == $past(over_torque))
        else $error("Output one does not follow over-torque.");
    chk_inhibit_follow: assert property (st && sel1 == FN_INHIBIT |->
        status_output_one == $past(output_inhibit || inhibit_forced_by_input))
        else $error("Output one does not follow the inhibit state.");
    chk_fault_follow: assert property (st && sel1 == FN_FAULT |->
        status_output_one == $past(protective_fault))
        else $error("Output one does not follow the fault state.");
    chk_ready_follow: assert property (st && sel1 == FN_READY |->
        status_output_one == $past(drive_powered && !abnormality))
        else $error("Output one does not follow readiness.");
    chk_nofreq_inverse: assert property (st && sel1 == FN_NO_FREQ |->
        status_output_one == !$past(output_freq_present))
        else $error("Output one does not invert frequency presence.");
    chk_none_off: assert property (st && (sel1 == FN_NONE || sel1 >= 6'h1e) |->
        !status_output_one)
        else $error("Output one is on with no function selected.");
    chk_step_pulse: assert property (step_rise |-> ##2 held8)
        else $error("Step pulse is too short.");
endmodule // sos_sel_asserts
bind sos_status_output_selector sos_sel_asserts chk_u (
    .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .output_active, .run_command, .over_torque, .output_inhibit,
    .inhibit_forced_by_input, .protective_fault, .drive_powered, .abnormality,
    .output_freq_present, .sequencer_step_reached, .status_output_one
);
`default_nettype wire

// *** testbench/tb_status_output_selector.sv ***
/* Self-checking bench for the status output selector over APB.
   Assumes a short pulse parameter and no other master on the bus. */
`timescale 1ns/1ps
`default_nettype none
module tb_status_output_selector;
    import sos_pkg::*;
    localparam int PL = 20; // Shortened pulse length.
    // Each entry: bit 15 inverted sense, bits 12:8 condition, bits 5:0 code.
    localparam logic [15:0] TBL [21] = '{16'h0001, 16'h0101, 16'h0202,
        16'h0303, 16'h0404, 16'h0505, 16'h0605, 16'h0706, 16'h0807, 16'h0908,
        16'h0a09, 16'h0b16, 16'h0c0a, 16'h0d0d, 16'h100e, 16'h110f, 16'h1213,
        16'h1314, 16'h1515, 16'h9618, 16'h1719};
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [26:0] cond    = 27'h0; // Condition inputs in port order.
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, rno, rnc, o1, o2, o3, e;
    logic [3:0]  load_seen;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          cnt;
    initial forever #20 sys_clk = ~sys_clk;
    sos_status_output_selector #(.PULSE_LEN(PL)) dut_u (.sys_clk, .sys_rst,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .output_active(cond[0]), .run_command(cond[1]), .freq_at_command(cond[2]),
        .command_below_min(cond[3]), .over_torque(cond[4]), .output_inhibit(cond[5]),
        .inhibit_forced_by_input(cond[6]), .bus_undervoltage(cond[7]),
        .command_from_terminals(cond[8]), .protective_fault(cond[9]),
        .target_one_reached(cond[10]), .target_two_reached(cond[11]),
        .sequencer_running(cond[12]), .sequencer_paused(cond[13]),
        .sequencer_step_reached(cond[14]), .sequencer_cycle_done(cond[15]),
        .count_final_reached(cond[16]), .count_prelim_reached(cond[17]),
        .heatsink_warning(cond[18]), .drive_powered(cond[19]), .abnormality(cond[20]),
        .emergency_stop(cond[21]), .output_freq_present(cond[22]),
        .current_below_min(cond[23]), .freq_at_brake_release(cond[24]),
        .freq_at_brake_engage(cond[25]), .stop_command(cond[26]),
        .relay_normally_open_contact(rno), .relay_normally_closed_contact(rnc),
        .status_output_one(o1), .status_output_two(o2), .status_output_three(o3));
    sos_load_model load_u (.sys_clk, .contact_no(rno), .contact_nc(rnc),
        .terminals({o3, o2, o1}), .load_seen);
    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Compares one value and counts the outcome.
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) begin
            error_cnt++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        apb(1'b0, ADDR_SEL_RELAY, 32'h0); cmp(rd, 32'h08);
        apb(1'b0, ADDR_SEL_ONE, 32'h0); cmp(rd, 32'h01);
        apb(1'b0, ADDR_SEL_TWO, 32'h0); cmp(rd, 32'h02);
        apb(1'b0, ADDR_SEL_THREE, 32'h0); cmp(rd, 32'h14);
        cmp(32'({rno, rnc, o1, o2, o3}), 32'h08);
        // Every implemented level function, on all four outputs at once.
        for (int i = 0; i < 21; i++) begin
            for (int k = 0; k < 4; k++) apb(1'b1, 12'(k * 4), {26'h0, TBL[i][5:0]});
            e = ~TBL[i][15];
            cond <= 27'h1 << TBL[i][12:8];
            repeat (2) @(posedge sys_clk);
            cmp(32'({rno, rnc, o1, o2, o3}), 32'({e, ~e, e, e, e}));
            apb(1'b0, ADDR_STATUS, 32'h0); cmp(rd, 32'({4{e}}));
            cmp(32'(load_seen), 32'({4{e}}));
            cond <= 27'h0;
            repeat (2) @(posedge sys_clk);
            cmp(32'({rno, rnc, o1, o2, o3}), 32'({~e, e, ~e, ~e, ~e}));
        end
        // Step and cycle pulses, with the event level held high throughout.
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, ADDR_SEL_ONE, 32'(FN_SEQ_STEP + j));
            // Let the new selector settle a cycle before the event rises.
            @(posedge sys_clk);
            cond <= 27'h1 << (14 + j);
            cnt = 0;
            repeat (3 * PL) begin
                @(posedge sys_clk);
                cnt += int'(o1 === 1'b1);
            end
            cmp(32'(cnt), 32'(PL));
            cond <= 27'h0;
        end
        // Brake hysteresis: engage alone keeps it set until a stop is seen.
        // The brake state adds one flip-flop ahead of the output register.
        apb(1'b1, ADDR_SEL_ONE, 32'(FN_BRAKE));
        cond <= 27'h1 << 24;
        repeat (3) @(posedge sys_clk);
        cmp(32'(o1), 32'h1);
        apb(1'b0, ADDR_CONDITION, 32'h0); cmp(rd, 32'h4);
        cond <= 27'h1 << 25;
        repeat (3) @(posedge sys_clk);
        cmp(32'(o1), 32'h1);
        cond <= 27'h3 << 25;
        repeat (3) @(posedge sys_clk);
        cmp(32'(o1), 32'h0);
        // Unimplemented and empty codes stay off; an oversize code is dropped.
        apb(1'b1, ADDR_SEL_ONE, 32'h1e);
        cond <= '1;
        apb(1'b1, ADDR_SEL_ONE, 32'h25);
        cmp(32'(o1), 32'h0);
        apb(1'b0, ADDR_SEL_ONE, 32'h0); cmp(rd, 32'h1e);
        apb(1'b1, ADDR_SEL_ONE, 32'h0);
        repeat (2) @(posedge sys_clk);
        cmp(32'(o1), 32'h0);
        apb(1'b0, 12'h020, 32'h0); cmp(32'(err), 32'h1);
        // A second reset in mid-run restores every selector default.
        sys_rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        apb(1'b0, ADDR_SEL_ONE, 32'h0); cmp(rd, 32'(RST_SEL_ONE));
        cmp(32'({rno, rnc, o1, o2, o3}), 32'h16);
        results();
    end
endmodule // tb_status_output_selector
`default_nettype wire
